// [verilog/i2c_pending_register_access.sv]
/*
 * two-wire slave port with a persistent pointer, pending command bytes applied
 * on stop, one-byte reads and interrupt-frozen status snapshots.
 * assumes scl and sda come from pins (synchronised here), while status, event,
 * power-loss and default-select inputs come from logic on clk.
 */
`timescale 1ns/1ps
`default_nettype none

// Contract
// - ack own write and read addresses, ignore others
// - pointer loads at its ack
// - data ack stores into pending holding
// - bytes alternate pointer then data
// - repeated start keeps pending, applies nothing
// - stop copies pending into command registers
// - seven readable registers: three status, four command
// - read returns register chosen by pointer
// - eight bits driven after read ack
// - further clocks read all ones
// - no ack of read data bytes
// - pointer persists across transactions
// - modified command reads return pending value
// - power loss resets both current limits
// - status snapshot at read address ack
// - unmasked event asserts irq, latches status
// - frozen reads until clear, then live
// - address 0x12 write, 0x13 read
// - eight bits msb first plus ack
// - never hold scl low
// - mask location write clears interrupt
module i2c_pending_register_access (
   input  wire logic       clk,          // system clock, 25 MHz
   input  wire logic       rst,          // synchronous reset, active high
   input  wire logic       ce,           // clock enable, freezes all state
   input  wire logic       scl_in,       // scl pin level
   input  wire logic       sda_in,       // sda pin level
   output logic            sda_out,      // sda drive value, always low
   output logic            sda_oe,       // high while pulling sda low
   output logic            scl_out,      // scl drive value, always low
   output logic            scl_oe,       // scl drive enable, never high
   input  wire logic       bus_logic_supply_ok, // bus supply above lockout
   input  wire logic [7:0] status0,      // live status byte 0
   input  wire logic [7:0] status1,      // live status byte 1
   input  wire logic [7:0] status2,      // live status byte 2
   input  wire logic [5:0] irq_events,   // event categories, one-cycle pulses
   input  wire logic       pwr_loss,     // input power removed pulse
   input  wire logic       alt_default,  // alternate default limit select
   output logic [7:0]      cmd0,         // active command register 0
   output logic [7:0]      cmd1,         // active command register 1
   output logic [7:0]      cmd2,         // active command register 2
   output logic [7:0]      irq_mask,     // active interrupt mask register
   output logic            irq_n         // interrupt request, active low
);

   // -------------------------------------------------------------------
   // pin synchronisers and edge detection
   // -------------------------------------------------------------------
   logic [1:0] scl_sync;   // scl two-flop chain
   logic [1:0] sda_sync;   // sda two-flop chain
   logic [1:0] sup_sync;   // supply-ok two-flop chain
   logic       scl_d;      // scl one sample later
   logic       sda_d;      // sda one sample later

   // the first flop of each chain feeds only the second
   always_ff @(posedge clk) begin
      if (rst) begin
         scl_sync <= 2'h3;
         sda_sync <= 2'h3;
         sup_sync <= 2'h0;
         scl_d    <= 1'b1;
         sda_d    <= 1'b1;
      end else if (ce) begin
         scl_sync <= {scl_sync[0], scl_in};
         sda_sync <= {sda_sync[0], sda_in};
         sup_sync <= {sup_sync[0], bus_logic_supply_ok};
         scl_d    <= scl_sync[1];
         sda_d    <= sda_sync[1];
      end
   end

   wire scl_s     = scl_sync[1];               // synchronised scl
   wire sda_s     = sda_sync[1];               // synchronised sda
   wire scl_rise  = scl_s && !scl_d;           // sample point
   wire scl_fall  = !scl_s && scl_d;           // drive change point
   wire start_det = scl_s && scl_d && sda_d && !sda_s;
   wire stop_det  = scl_s && scl_d && !sda_d && sda_s;
   // low bus supply clears the port and the configuration
   wire clr       = rst || !sup_sync[1];

   // -------------------------------------------------------------------
   // port state
   // -------------------------------------------------------------------
   pm_i2c_pkg::port_state_t state;       // port state machine
   pm_i2c_pkg::port_state_t next_state;  // its next value
   logic [3:0] bit_cnt;    // bits sampled in the current byte
   logic [7:0] shift;      // received byte, msb first
   logic [7:0] tx;         // byte being sent
   logic [7:0] ptr;        // sub-address pointer
   logic       want_ptr;   // next written byte is a pointer
   logic       irq_pend;   // interrupt pending
   logic [7:0] frz [3];    // frozen status bytes
   logic [7:0] bank_rd;    // registered command read-back

   // -------------------------------------------------------------------
   // decodes
   // -------------------------------------------------------------------
   wire byte_end  = scl_fall && (bit_cnt == 4'h8);
   wire addr_hit  = (shift[7:1] == pm_i2c_pkg::SLAVE_ADDR);
   wire rd_bit    = shift[0];
   wire ptr_cmd   = (ptr <= pm_i2c_pkg::SUB_CMD2) || (ptr == pm_i2c_pkg::SUB_MASK);
   wire ptr_stat  = (ptr >= pm_i2c_pkg::SUB_STAT0) && (ptr <= pm_i2c_pkg::SUB_STAT2);
   wire [1:0] ptr_idx  = (ptr == pm_i2c_pkg::SUB_MASK) ? 2'h3 : ptr[1:0];
   wire [1:0] stat_idx = 2'(ptr - pm_i2c_pkg::SUB_STAT0);
   wire data_ack  = (state == pm_i2c_pkg::ST_WR) && byte_end && !want_ptr;
   // a data byte aimed at a status location is acked and dropped
   wire bank_wr   = data_ack && ptr_cmd;
   wire irq_clr   = data_ack && (ptr == pm_i2c_pkg::SUB_MASK);
   wire irq_set   = |(irq_events & irq_mask[7:pm_i2c_pkg::MASK_LSB]);
   wire [7:0] live_stat = (stat_idx == 2'h0) ? status0 :
                          (stat_idx == 2'h1) ? status1 : status2;
   wire [7:0] frz_stat  = frz[stat_idx];
   // status reads use the frozen copy while an interrupt is pending
   wire [7:0] stat_val  = irq_pend ? frz_stat : live_stat;
   wire [7:0] rd_sel    = ptr_stat ? stat_val :
                          ptr_cmd  ? bank_rd  : pm_i2c_pkg::UNMAPPED_RD;

   // -------------------------------------------------------------------
   // next-state decode
   // -------------------------------------------------------------------
   always_comb begin
      next_state = state;
      if (start_det) begin
         next_state = pm_i2c_pkg::ST_ADDR;
      end else if (stop_det) begin
         next_state = pm_i2c_pkg::ST_IDLE;
      end else if (scl_fall) begin
         case (state)
            pm_i2c_pkg::ST_ADDR: begin
               if (byte_end) begin
                  // foreign addresses leave the bus alone
                  if (!addr_hit) next_state = pm_i2c_pkg::ST_IDLE;
                  else if (rd_bit) next_state = pm_i2c_pkg::ST_RACK;
                  else next_state = pm_i2c_pkg::ST_WACK;
               end
            end
            pm_i2c_pkg::ST_WACK: next_state = pm_i2c_pkg::ST_WR;
            pm_i2c_pkg::ST_WR: begin
               if (byte_end) next_state = pm_i2c_pkg::ST_WACK;
            end
            pm_i2c_pkg::ST_RACK: next_state = pm_i2c_pkg::ST_RD;
            pm_i2c_pkg::ST_RD: begin
               if (byte_end) next_state = pm_i2c_pkg::ST_IGN;
            end
            pm_i2c_pkg::ST_IDLE: next_state = pm_i2c_pkg::ST_IDLE;
            pm_i2c_pkg::ST_IGN:  next_state = pm_i2c_pkg::ST_IGN;
            default: next_state = pm_i2c_pkg::ST_IDLE;
         endcase
      end
   end

   // -------------------------------------------------------------------
   // state, bit counter and receive shifter
   // -------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (clr) begin
         state   <= pm_i2c_pkg::ST_IDLE;
         bit_cnt <= 4'h0;
         shift   <= 8'h00;
      end else if (ce) begin
         state <= next_state;
         if (start_det || (scl_fall && (next_state != state))) begin
            bit_cnt <= 4'h0;
         end else if (scl_rise && (bit_cnt != 4'h8)) begin
            bit_cnt <= bit_cnt + 4'h1;
            shift   <= {shift[6:0], sda_s};
         end
      end
   end

   // -------------------------------------------------------------------
   // pointer and pointer/data alternation
   // -------------------------------------------------------------------
   // the pointer is never cleared by a transaction, only by reset or lockout
   always_ff @(posedge clk) begin
      if (clr) begin
         ptr      <= pm_i2c_pkg::PTR_RST;
         want_ptr <= 1'b1;
      end else if (ce) begin
         if ((state == pm_i2c_pkg::ST_ADDR) && byte_end) begin
            want_ptr <= 1'b1;
         end else if ((state == pm_i2c_pkg::ST_WR) && byte_end) begin
            want_ptr <= !want_ptr;
            if (want_ptr) ptr <= shift;
         end
      end
   end

   // -------------------------------------------------------------------
   // sda drive: acks and the single read byte
   // -------------------------------------------------------------------
   // drive changes only just after scl falls, so a start or stop is never faked
   always_ff @(posedge clk) begin
      if (clr) begin
         sda_oe <= 1'b0;
         tx     <= 8'hFF;
      end else if (ce) begin
         if (start_det || stop_det) begin
            sda_oe <= 1'b0;
         end else if (scl_fall) begin
            case (state)
               pm_i2c_pkg::ST_ADDR: begin
                  sda_oe <= byte_end && addr_hit;
                  if (byte_end && addr_hit && rd_bit) tx <= rd_sel;
               end
               pm_i2c_pkg::ST_WR: sda_oe <= byte_end;
               pm_i2c_pkg::ST_RACK: begin
                  sda_oe <= !tx[7];
                  tx     <= {tx[6:0], 1'b1};
               end
               pm_i2c_pkg::ST_RD: begin
                  // after eight bits the line is released for good
                  sda_oe <= !byte_end && !tx[7];
                  tx     <= {tx[6:0], 1'b1};
               end
               default: sda_oe <= 1'b0;
            endcase
         end
      end
   end

   // -------------------------------------------------------------------
   // interrupt and status freeze
   // -------------------------------------------------------------------
   // an event in the clearing cycle wins, so no event is lost
   always_ff @(posedge clk) begin
      if (clr) begin
         irq_pend <= 1'b0;
         irq_n    <= 1'b1;
      end else if (ce) begin
         if (irq_set) begin
            irq_pend <= 1'b1;
            irq_n    <= 1'b0;
         end else if (irq_clr) begin
            irq_pend <= 1'b0;
            irq_n    <= 1'b1;
         end
      end
   end

   // each frozen byte latches on a new event only, holding the first cause
   genvar g;
   generate
      for (g = 0; g < 3; g = g + 1) begin : g_frz
         wire [7:0] live = (g == 0) ? status0 : (g == 1) ? status1 : status2;
         always_ff @(posedge clk) begin
            if (clr) begin
               frz[g] <= 8'h00;
            end else if (ce && irq_set && (!irq_pend || irq_clr)) begin
               frz[g] <= live;
            end
         end
      end
   endgenerate

   // -------------------------------------------------------------------
   // command registers
   // -------------------------------------------------------------------
   cmd_bank u_bank (
      .clk         (clk),
      .clr         (clr),
      .ce          (ce),
      .wr_en       (bank_wr),
      .wr_idx      (ptr_idx),
      .wr_data     (shift),
      .commit      (stop_det),
      .pwr_loss    (pwr_loss),
      .alt_default (alt_default),
      .rd_idx      (ptr_idx),
      .rd_data     (bank_rd),
      .act0        (cmd0),
      .act1        (cmd1),
      .act2        (cmd2),
      .act3        (irq_mask)
   );

   // -------------------------------------------------------------------
   // constant pin drives
   // -------------------------------------------------------------------
   // scl is never driven: no stretching in any state
   always_ff @(posedge clk) begin
      if (rst) begin
         sda_out <= 1'b0;
         scl_out <= 1'b0;
         scl_oe  <= 1'b0;
      end else if (ce) begin
         sda_out <= 1'b0;
         scl_out <= 1'b0;
         scl_oe  <= 1'b0;
      end
   end

endmodule // i2c_pending_register_access

`default_nettype wire

// [pkg/pm_i2c_pkg.sv]
/*
 * constants of the two-wire command/status port and its register bank.
 * assumes one clock domain for all users.
 */
package pm_i2c_pkg;

   // -------------------------------------------------------------------
   // slave address
   // -------------------------------------------------------------------
   localparam logic [6:0] SLAVE_ADDR  = 7'h09;   // write form 0x12, read form 0x13

   // -------------------------------------------------------------------
   // sub-address map
   // -------------------------------------------------------------------
   localparam logic [7:0] SUB_CMD0    = 8'h00;   // command register 0
   localparam logic [7:0] SUB_CMD1    = 8'h01;   // command register 1
   localparam logic [7:0] SUB_CMD2    = 8'h02;   // command register 2
   localparam logic [7:0] SUB_STAT0   = 8'h03;   // status register 0
   localparam logic [7:0] SUB_STAT1   = 8'h04;   // status register 1
   localparam logic [7:0] SUB_STAT2   = 8'h05;   // status register 2
   localparam logic [7:0] SUB_MASK    = 8'h06;   // interrupt mask, write clears irq

   // -------------------------------------------------------------------
   // reset values and fields
   // -------------------------------------------------------------------
   localparam logic [7:0] CMD_RST     = 8'h00;   // every command register
   localparam logic [7:0] PTR_RST     = 8'h00;   // sub-address pointer
   localparam logic [7:0] UNMAPPED_RD = 8'h00;   // read of an unmapped location
   localparam int         ILIM_LSB    = 0;       // current limit field position
   localparam int         ILIM_W      = 5;       // current limit field width
   localparam logic [4:0] ILIM_MIN    = 5'h00;   // minimum-current code
   localparam logic [4:0] ILIM_EXT    = 5'h1F;   // external_program_limit_mode code
   localparam logic [1:0] IDX_USB     = 2'h0;    // entry with usb_input_current_limit
   localparam logic [1:0] IDX_ADAPTER = 2'h1;    // entry with adapter_input_current_limit
   localparam int         MASK_LSB    = 2;       // mask bits sit in [7:2]

   // -------------------------------------------------------------------
   // port state machine
   // -------------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE,   // not addressed, sda released
      ST_ADDR,   // shifting the address byte
      ST_WACK,   // driving ack of a received byte
      ST_WR,     // shifting a pointer or data byte
      ST_RACK,   // driving ack of the read address
      ST_RD,     // shifting the single read byte out
      ST_IGN     // released until the next start or stop
   } port_state_t;

endpackage

// [verilog/cmd_bank.sv]
/*
 * four command registers, each with a pending copy and a modified flag.
 * assumes writes, commits and power loss come from logic on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none

module cmd_bank (
   input  wire logic       clk,          // system clock
   input  wire logic       clr,          // synchronous clear, active high
   input  wire logic       ce,           // clock enable
   input  wire logic       wr_en,        // store a pending byte
   input  wire logic [1:0] wr_idx,       // entry for the pending byte
   input  wire logic [7:0] wr_data,      // pending byte
   input  wire logic       commit,       // stop seen: apply pending bytes
   input  wire logic       pwr_loss,     // input power removed pulse
   input  wire logic       alt_default,  // select the all-ones limit code
   input  wire logic [1:0] rd_idx,       // entry to read back
   output logic      [7:0] rd_data,      // registered read-back byte
   output logic      [7:0] act0,         // active command register 0
   output logic      [7:0] act1,         // active command register 1
   output logic      [7:0] act2,         // active command register 2
   output logic      [7:0] act3          // active command register 3
);

   logic [7:0] act  [4];   // active values
   logic [7:0] pend [4];   // pending values
   logic [3:0] dirty;      // pending written since the last commit
   wire  [4:0] ilim_dflt = alt_default ? pm_i2c_pkg::ILIM_EXT : pm_i2c_pkg::ILIM_MIN;

   // -------------------------------------------------------------------
   // one entry per command register
   // -------------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1) begin : g_ent
         wire hit      = wr_en && (wr_idx == 2'(g));
         wire has_ilim = (2'(g) == pm_i2c_pkg::IDX_USB) || (2'(g) == pm_i2c_pkg::IDX_ADAPTER);
         // pending copy and flag; a write in the commit cycle stays pending
         always_ff @(posedge clk) begin
            if (clr) begin
               pend[g]  <= pm_i2c_pkg::CMD_RST;
               dirty[g] <= 1'b0;
            end else if (ce) begin
               if (hit) begin
                  pend[g]  <= wr_data;
                  dirty[g] <= 1'b1;
               end else if (commit) begin
                  dirty[g] <= 1'b0;
               end
            end
         end
         // active copy: commit applies, power loss overrides the limit field
         always_ff @(posedge clk) begin
            if (clr) begin
               act[g] <= pm_i2c_pkg::CMD_RST;
            end else if (ce) begin
               if (commit && dirty[g] && !hit) begin
                  act[g] <= pend[g];
               end
               if (pwr_loss && has_ilim) begin
                  act[g][pm_i2c_pkg::ILIM_LSB +: pm_i2c_pkg::ILIM_W] <= ilim_dflt;
               end
            end
         end
      end
   endgenerate

   // -------------------------------------------------------------------
   // read port: modified entries show their pending byte
   // -------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (clr) begin
         rd_data <= pm_i2c_pkg::CMD_RST;
      end else if (ce) begin
         rd_data <= dirty[rd_idx] ? pend[rd_idx] : act[rd_idx];
      end
   end

   assign act0 = act[0];
   assign act1 = act[1];
   assign act2 = act[2];
   assign act3 = act[3];

endmodule // cmd_bank

`default_nettype wire

// [sim/i2c_pending_register_access_chk.sv]
/* pin-level assertions for the pending register port.
   assumes one clk domain, sync active high rst; attached by bind. */
`timescale 1ns/1ps
`default_nettype none
module i2c_pending_register_access_chk (
   input wire logic       clk, rst, scl_in, sda_in,         // clock, reset, pins
   input wire logic       sda_out, sda_oe, scl_out, scl_oe, // pin drivers
   input wire logic       bus_logic_supply_ok, pwr_loss, alt_default, // clears, default select
   input wire logic [5:0] irq_events,                       // event pulses
   input wire logic [7:0] cmd0, cmd1, cmd2, irq_mask,       // active registers
   input wire logic       irq_n                             // request, active low
);
   logic scl_q, sda_q, ev_hit; // last pin levels, unmasked event seen
   int   quiet, oe_cnt;        // since stop or clear; sda held
   wire  stop_seen = scl_q && scl_in && !sda_q && sda_in; // sda rose, scl high
   // ------------------
   // helper counters
   // ------------------
   always_ff @(posedge clk) begin
      scl_q  <= scl_in;
      sda_q  <= sda_in;
      ev_hit <= |(irq_events & irq_mask[7:2]);
      quiet  <= (rst || pwr_loss || !bus_logic_supply_ok || stop_seen) ? 0 : quiet + 1;
      oe_cnt <= sda_oe ? oe_cnt + 1 : 0;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   a_scl_never_held: assert property (!scl_oe && !scl_out && !sda_out)
      else $error("scl driven or sda drive value high");
   a_cmd_only_commit: assert property ($changed({cmd0, cmd1, cmd2, irq_mask}) |-> quiet < 8)
      else $error("command changed without a stop");
   a_sda_change_low: assert property ($changed(sda_oe) |-> !$past(scl_in))
      else $error("sda drive changed while scl high");
   a_irq_on_event: assert property (|(irq_events & irq_mask[7:2]) |=> !irq_n)
      else $error("unmasked event gave no request");
   a_irq_fall_cause: assert property ($fell(irq_n) |-> ev_hit)
      else $error("request without an unmasked event");
   a_oe_released: assert property (oe_cnt < 80)
      else $error("sda held too long");
   a_reset_values: assert property ($fell(rst) |-> {cmd0, cmd1, cmd2, irq_mask} == 32'h0 && irq_n)
      else $error("wrong value after reset");
   a_power_loss_limit: assert property (pwr_loss |=> {cmd0[4:0], cmd1[4:0]} == {10{$past(alt_default)}})
      else $error("limits not defaulted");
endmodule // i2c_pending_register_access_chk
bind i2c_pending_register_access i2c_pending_register_access_chk i2c_pending_register_access_chk_i (
   .clk, .rst, .scl_in, .sda_in, .sda_out, .sda_oe, .scl_out, .scl_oe, .bus_logic_supply_ok,
   .pwr_loss, .alt_default, .irq_events, .cmd0, .cmd1, .cmd2, .irq_mask, .irq_n);
`default_nettype wire

// [sim/i2c_master_model.sv]
/* bus master model: start, stop, byte write and byte read.
   assumes an open-drain sda with a pull-up in the bench. */
`timescale 1ns/1ps
`default_nettype none
module i2c_master_model (
   input  wire logic clk,     // bench clock, 2 cycles per quarter scl
   input  wire logic sda,     // resolved sda wire
   output logic      scl,     // idle high and still between frames
   output logic      sda_drv  // 0 pulls sda low, 1 releases it
);
   initial {scl, sda_drv} = 2'h3;
   // one quarter scl period, changed just after an edge
   task automatic ph(input logic c, input logic d);
      scl <= c;
      sda_drv <= d;
      repeat (2) @(posedge clk);
   endtask
   // one bit: data moves while scl is low, sampled halfway through the high
   task automatic xb(input logic b, output logic r);
      ph(1'b0, sda_drv);
      ph(1'b0, b);
      ph(1'b1, b);
      r = sda;
      ph(1'b1, b);
   endtask
   task automatic start; // also repeated: scl low first frees a held ack
      ph(1'b0, 1'b1);
      ph(1'b0, 1'b1);
      ph(1'b1, 1'b1);
      ph(1'b1, 1'b0);
   endtask
   task automatic stop;
      ph(1'b0, sda_drv);
      ph(1'b0, 1'b0);
      ph(1'b1, 1'b0);
      ph(1'b1, 1'b1);
   endtask
   task automatic wbyte(input logic [7:0] b, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) xb(b[i], r);
      xb(1'b1, ack);
   endtask
   task automatic rbyte(output logic [7:0] d, output logic slot);
      for (int i = 7; i >= 0; i--) xb(1'b1, d[i]);
      xb(1'b1, slot); // master answers no ack
   endtask
endmodule // i2c_master_model
`default_nettype wire

// [sim/i2c_pending_register_access_bench.sv]
/* bench: master model, reference model and compares for the port.
   assumes a 25 MHz clk. */
`timescale 1ns/1ps
`default_nettype none
module i2c_pending_register_access_bench;
   logic        clk = 1'b0, rst = 1'b1, pwr_loss = 1'b0, alt_default = 1'b0; // inputs
   logic [7:0]  st [3] = '{8'h00, 8'h00, 8'h00}; // live status bytes
   logic [5:0]  irq_events = 6'h00;              // event pulses
   logic [7:0]  act [8], pend [8], frz [3], d;   // reference bytes, read byte
   bit          mod [8], irq, own;               // reference flags
   logic        a;                               // ack or slot level seen
   int          err_total = 0, samples_checked = 0, ptr = 0, pos = 0;
   logic [31:0] x = 32'h5A;                      // xorshift state
   wire         scl, sda_m, sda_oe, irq_n;
   wire   [7:0] cmd0, cmd1, cmd2, irq_mask;
   wire         sda = sda_m & ~sda_oe;           // open drain, pulled up
   initial forever #20 clk = ~clk;
   i2c_pending_register_access i2c_pending_register_access_i (.clk, .rst, .ce(1'b1),
      .scl_in(scl), .sda_in(sda), .sda_out(), .sda_oe, .scl_out(), .scl_oe(),
      .bus_logic_supply_ok(1'b1), .status0(st[0]), .status1(st[1]), .status2(st[2]),
      .irq_events, .pwr_loss, .alt_default, .cmd0, .cmd1, .cmd2, .irq_mask, .irq_n);
   i2c_master_model i2c_master_model_i (.clk, .sda, .scl, .sda_drv(sda_m));
   function automatic logic [7:0] rnd;
      x ^= x << 13;
      x ^= x >> 17;
      x ^= x << 5;
      return x[7:0];
   endfunction
   function automatic logic [7:0] expv; // frozen status while irq
      if (ptr >= 3 && ptr <= 5) return irq ? frz[ptr-3] : st[ptr-3];
      if (ptr > 6) return 8'h00;
      return mod[ptr] ? pend[ptr] : act[ptr];
   endfunction
   task automatic chk(input string n, input logic [7:0] e, g);
      samples_checked++;
      if (g !== e) begin
         err_total++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic sa(input logic [7:0] b); // start and address byte
      i2c_master_model_i.start;
      i2c_master_model_i.wbyte(b, a);
      own = (b[7:1] == pm_i2c_pkg::SLAVE_ADDR);
      pos = 0;
      chk("addr ack", 8'(!own), 8'(a));
   endtask
   task automatic wb(input logic [7:0] b); // pointer on odd bytes, data on even
      i2c_master_model_i.wbyte(b, a);
      chk("byte ack", 8'(!own), 8'(a));
      if (own && pos % 2 == 0) ptr = b;
      else if (own && (ptr < 3 || ptr == 6)) {pend[ptr], mod[ptr]} = {b, 1'b1};
      if (own && pos % 2 == 1 && ptr == 6) irq = 0;
      pos++;
   endtask
   task automatic cmds;
      chk("cmd0", act[0], cmd0);
      chk("cmd1", act[1], cmd1);
      chk("cmd2", act[2], cmd2);
      chk("irq_mask", act[6], irq_mask);
      chk("irq_n", 8'(!irq), 8'(irq_n));
   endtask
   task automatic sp; // stop commits all pending
      i2c_master_model_i.stop;
      foreach (mod[i]) if (mod[i]) {act[i], mod[i]} = {pend[i], 1'b0};
      repeat (6) @(posedge clk);
      cmds;
   endtask
   task automatic rd; // one byte, then a released one
      sa(8'h13);
      i2c_master_model_i.rbyte(d, a);
      chk("read byte", expv(), d);
      chk("read ack slot", 8'h01, 8'(a));
      i2c_master_model_i.rbyte(d, a);
      chk("extra byte", 8'hFF, d);
   endtask
   task automatic pulse(input logic [5:0] ev, input logic pl); // one-cycle inputs
      @(posedge clk);
      irq_events <= ev;
      pwr_loss <= pl;
      @(posedge clk);
      irq_events <= 6'h00;
      pwr_loss <= 1'b0;
      if (!irq) frz = st;
      irq |= |(ev & act[6][7:2]);
      if (pl) {act[0][4:0], act[1][4:0]} = {10{alt_default}};
      repeat (4) @(posedge clk);
      cmds;
   endtask
   task automatic summarize;
      $display("checks %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // watchdog: a run takes about 0.3 ms
   initial begin
      #3000000;
      err_total++;
      summarize;
   end
   initial begin
      foreach (act[i]) {act[i], pend[i], mod[i]} = 17'h00000;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      repeat (6) @(posedge clk);
      cmds; // reset values
      pulse(6'h3F, 1'b0); // masked: no request
      $display("test reset done");
      sa(8'h12);
      for (int i = 0; i < 3; i++) begin
         wb(8'(i));
         wb(rnd());
      end
      wb(8'h06); // pointer only
      sa(8'h20); // foreign target
      wb(rnd());
      sa(8'h12);
      wb(8'h06);
      wb(8'hFC); // unmask all
      cmds; // not applied yet
      sp;
      sa(8'h12);
      wb(8'h02);
      wb(rnd());
      rd; // pending byte
      sp;
      rd; // pointer kept
      sp;
      $display("test group commit done");
      for (int p = 3; p < 6; p++) begin
         @(posedge clk) foreach (st[i]) st[i] <= rnd();
         sa(8'h12);
         wb(8'(p));
         wb(rnd()); // no effect
         wb(8'(p));
         sp;
         rd; // live snapshot
         sp;
      end
      $display("test status done");
      for (int k = 0; k < 6; k++) begin
         pulse(6'(1 << k), 1'b0);
         @(posedge clk) foreach (st[i]) st[i] <= rnd();
         rd; // frozen bytes
         sa(8'h12);
         wb(8'h06);
         wb(8'hFC); // clears
         wb(8'(3 + k % 3));
         sp;
         rd; // live bytes again
         sp;
      end
      $display("test interrupt done");
      for (int v = 0; v < 2; v++) begin
         @(posedge clk) alt_default <= v[0];
         pulse(6'h00, 1'b1);
      end
      $display("test power loss done");
      summarize;
   end
endmodule // i2c_pending_register_access_bench
`default_nettype wire
